// ---- inc/cci_pkg.sv ----
package cci_pkg;

    // ------------------------------------------------------------------
    // Port widths and function count
    // ------------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int SEL_W = 2;
    localparam int FUNC_N = 4;

    // ------------------------------------------------------------------
    // Function selector codes
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_ADD = 2'h0;
    localparam logic [1:0] SEL_XOR = 2'h1;
    localparam logic [1:0] SEL_MUL = 2'h2;
    localparam logic [1:0] SEL_ROT = 2'h3;

    // ------------------------------------------------------------------
    // Fixed latency of each internal function, in clock cycles
    // ------------------------------------------------------------------
    localparam int LAT_ADD = 1;
    localparam int LAT_XOR = 1;
    localparam int LAT_MUL = 3;
    localparam int LAT_ROT = 2;
    localparam int LAT_MAX = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        CCI_IDLE = 2'b01,
        CCI_BUSY = 2'b10
    } cci_state_t;

endpackage : cci_pkg

// ---- hw/cci_start_chain.sv ----
`timescale 1ns/1ps
// Delays a start pulse by DEPTH cycles to form one function's done.
module cci_start_chain #(
    parameter int DEPTH = 1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic start_in,
    output logic done_out
);
    logic [DEPTH-1:0] chain_ff;

    // A one-stage chain has no older bits to shift, so its part-select must never be built.
    generate
        if (DEPTH == 1) begin : g_single
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    chain_ff <= '0;
                end else if (clk_en) begin
                    chain_ff <= start_in;
                end
            end
        end else begin : g_shift
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    chain_ff <= '0;
                end else if (clk_en) begin
                    chain_ff <= {chain_ff[DEPTH-2:0], start_in};
                end
            end
        end
    endgenerate

    assign done_out = chain_ff[DEPTH-1];
endmodule : cci_start_chain

// ---- hw/cci_unit.sv ----
`timescale 1ns/1ps
module cci_unit (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [1:0] n,
    input wire logic [31:0] dataa,
    input wire logic [31:0] datab,
    output logic [31:0] result,
    output logic done
);
    // ------------------------------------------------------------------
    // Operand capture
    // ------------------------------------------------------------------
    logic [31:0] opa_ff;
    logic [31:0] opb_ff;
    logic [1:0] sel_ff;
    cci_pkg::cci_state_t state_ff;
    logic start_ok;

    // A start while busy would break the blocking contract; it is ignored.
    assign start_ok = start && (state_ff == cci_pkg::CCI_IDLE);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            opa_ff <= cci_pkg::RESULT_RST;
            opb_ff <= cci_pkg::RESULT_RST;
            sel_ff <= cci_pkg::SEL_ADD;
        end else if (clk_en && start_ok) begin
            opa_ff <= dataa;
            opb_ff <= datab;
            sel_ff <= n;
        end
    end

    // ------------------------------------------------------------------
    // Selector decode
    // ------------------------------------------------------------------
    function automatic logic [3:0] sel_onehot(input logic [1:0] s);
        sel_onehot = 4'h1 << s;
    endfunction : sel_onehot

    logic [3:0] func_start;
    logic [3:0] func_done;
    assign func_start = start_ok ? sel_onehot(n) : 4'h0;

    // ------------------------------------------------------------------
    // Per-function sequencing chains
    // ------------------------------------------------------------------
    localparam int LATS [4] = '{cci_pkg::LAT_ADD, cci_pkg::LAT_XOR,
                                cci_pkg::LAT_MUL, cci_pkg::LAT_ROT};
    genvar gi;
    generate
        for (gi = 0; gi < cci_pkg::FUNC_N; gi++) begin : g_chain
            cci_start_chain #(
                .DEPTH(LATS[gi])
            ) u_chain (
                .clock(clock),
                .rst(rst),
                .clk_en(clk_en),
                .start_in(func_start[gi]),
                .done_out(func_done[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Functions; the multiplier is pipelined to match its chain depth
    // ------------------------------------------------------------------
    logic [31:0] mul_p1_ff;
    logic [31:0] mul_p2_ff;
    logic [31:0] rot_p1_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mul_p1_ff <= cci_pkg::RESULT_RST;
            mul_p2_ff <= cci_pkg::RESULT_RST;
            rot_p1_ff <= cci_pkg::RESULT_RST;
        end else if (clk_en) begin
            mul_p1_ff <= 32'(opa_ff * opb_ff);
            mul_p2_ff <= mul_p1_ff;
            rot_p1_ff <= (opa_ff << opb_ff[4:0]) | (opa_ff >> (6'h20 - {1'b0, opb_ff[4:0]}));
        end
    end

    logic [31:0] nxt_result;
    always_comb begin
        case (sel_ff)
            cci_pkg::SEL_ADD: nxt_result = 32'(opa_ff + opb_ff);
            cci_pkg::SEL_XOR: nxt_result = opa_ff ^ opb_ff;
            cci_pkg::SEL_MUL: nxt_result = mul_p2_ff;
            cci_pkg::SEL_ROT: nxt_result = rot_p1_ff;
            default: nxt_result = cci_pkg::RESULT_RST;
        endcase
    end

    // ------------------------------------------------------------------
    // Registered output stage
    // ------------------------------------------------------------------
    logic any_done;
    logic [31:0] result_ff;
    logic done_ff;
    assign any_done = |func_done;

    // Result and done share one register stage so latency stays consistent.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            result_ff <= cci_pkg::RESULT_RST;
            done_ff <= 1'b0;
        end else if (clk_en) begin
            done_ff <= any_done;
            if (any_done) begin
                result_ff <= nxt_result;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= cci_pkg::CCI_IDLE;
        end else if (clk_en) begin
            case (state_ff)
                cci_pkg::CCI_IDLE: if (start_ok) state_ff <= cci_pkg::CCI_BUSY;
                cci_pkg::CCI_BUSY: if (done_ff) state_ff <= cci_pkg::CCI_IDLE;
                default: state_ff <= cci_pkg::CCI_IDLE;
            endcase
        end
    end

    assign result = result_ff;
    assign done = done_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // A start only counts on an enabled edge; a frozen edge takes nothing.
    sequence s_start_add;
        clk_en && start_ok && n == cci_pkg::SEL_ADD;
    endsequence
    sequence s_start_mul;
        clk_en && start_ok && n == cci_pkg::SEL_MUL;
    endsequence
    sequence s_start_rot;
        clk_en && start_ok && n == cci_pkg::SEL_ROT;
    endsequence

    chk_done_single: assert property (@(posedge clock) disable iff (rst)
        clk_en && done |=> !done)
        else $error("done held longer than one cycle");
    chk_add_latency: assert property (@(posedge clock) disable iff (rst)
        s_start_add ##1 clk_en ##1 clk_en |-> done)
        else $error("add done not at second cycle");
    chk_mul_latency: assert property (@(posedge clock) disable iff (rst)
        s_start_mul ##1 clk_en [*4] |-> done && $past(done, 1) == 1'b0)
        else $error("mul done not at fourth cycle");
    chk_rot_latency: assert property (@(posedge clock) disable iff (rst)
        s_start_rot ##1 clk_en [*3] |-> done && $past(done, 1) == 1'b0)
        else $error("rotate done not at third cycle");
    chk_mul_value: assert property (@(posedge clock) disable iff (rst)
        s_start_mul ##1 clk_en [*4] |-> result == 32'($past(dataa, 4) * $past(datab, 4)))
        else $error("multiply result wrong");
    chk_add_value: assert property (@(posedge clock) disable iff (rst)
        s_start_add ##1 clk_en ##1 clk_en |-> result == 32'($past(dataa, 2) + $past(datab, 2)))
        else $error("add result wrong");
    chk_busy_state: assert property (@(posedge clock) disable iff (rst)
        clk_en && start_ok |=> state_ff == cci_pkg::CCI_BUSY)
        else $error("start not taken");
    chk_decode_hot: assert property (@(posedge clock) disable iff (rst)
        start_ok |-> func_start[n] && $onehot(func_start))
        else $error("selector decode wrong");
    chk_result_hold: assert property (@(posedge clock) disable iff (rst)
        clk_en && !any_done |=> $stable(result))
        else $error("result changed without done");
    // Stated forward, since a stall between completion and done would fool a look back.
    chk_done_cause: assert property (@(posedge clock) disable iff (rst)
        clk_en && !any_done |=> !done)
        else $error("done without function completion");
endmodule : cci_unit

// ---- bench/cci_proc_model.sv ----
`timescale 1ns/1ps
// Processor side of the port: one blocking operation at a time.
module cci_proc_model (
    input wire logic clock,
    input wire logic clk_en,
    input wire logic done,
    input wire logic [31:0] result,
    output logic start,
    output logic [1:0] n,
    output logic [31:0] dataa,
    output logic [31:0] datab
);
    initial begin
        start = 1'b0;
        n = 2'h0;
        dataa = 32'h0000_0000;
        datab = 32'h0000_0000;
    end

    // Operands are inverted once taken, so a unit that rereads them is caught.
    task automatic issue(input logic [1:0] sel, input logic [31:0] a, input logic [31:0] b,
                         input bit poke, output logic [31:0] res, output int lat,
                         output logic tail);
        logic got;
        start <= 1'b1;
        n <= sel;
        dataa <= a;
        datab <= b;
        do @(posedge clock); while (clk_en !== 1'b1);
        #1;
        start <= poke;
        n <= ~sel;
        dataa <= ~a;
        datab <= ~b;
        lat = 0;
        got = 1'b0;
        // Done and result are taken as they stand at an enabled edge, before it updates them.
        while (!got && lat < 20) begin
            @(posedge clock);
            if (clk_en === 1'b1) begin
                lat++;
                got = (done === 1'b1);
                res = result;
            end
            #1;
            start <= 1'b0;
        end
        do @(posedge clock); while (clk_en !== 1'b1);
        tail = done;
        #1;
        if (poke) begin
            repeat (6) begin
                @(posedge clock);
                #1;
                tail = tail | done;
            end
        end
    endtask : issue
endmodule : cci_proc_model

// ---- bench/combined_custom_instruction_bench.sv ----
`timescale 1ns/1ps
module combined_custom_instruction_bench;
    logic clock, rst, clk_en, start, done, stall;
    logic [1:0] n;
    logic [31:0] dataa, datab, result, last;
    int err_count = 0, tests_run = 0, cyc = 0, seed = 44;
    logic [31:0] exp_q[$];

    cci_unit uut (.clock(clock), .rst(rst), .clk_en(clk_en), .start(start), .n(n),
        .dataa(dataa), .datab(datab), .result(result), .done(done));
    cci_proc_model pm (.clock(clock), .clk_en(clk_en), .done(done), .result(result),
        .start(start), .n(n), .dataa(dataa), .datab(datab));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Random stalls freeze the unit; latency is counted in enabled edges only.
    always @(posedge clock) begin
        #1;
        clk_en <= stall ? 1'($random(seed)) : 1'b1;
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    function automatic logic [31:0] model_res(input logic [1:0] sel, input logic [31:0] a,
                                              input logic [31:0] b);
        logic [63:0] p;
        p = {a, a} << b[4:0];
        case (sel)
            cci_pkg::SEL_ADD: return a + b;
            cci_pkg::SEL_XOR: return a ^ b;
            cci_pkg::SEL_MUL: return a * b;
            default: return p[63:32];
        endcase
    endfunction : model_res

    task automatic run_op(input logic [1:0] sel, input logic [31:0] a, input logic [31:0] b,
                          input bit poke);
        logic [31:0] res;
        logic tail;
        int lat, exp_lat;
        case (sel)
            cci_pkg::SEL_ADD: exp_lat = cci_pkg::LAT_ADD + 1;
            cci_pkg::SEL_XOR: exp_lat = cci_pkg::LAT_XOR + 1;
            cci_pkg::SEL_MUL: exp_lat = cci_pkg::LAT_MUL + 1;
            default: exp_lat = cci_pkg::LAT_ROT + 1;
        endcase
        check(result, last);
        exp_q.push_back(model_res(sel, a, b));
        pm.issue(sel, a, b, poke, res, lat, tail);
        check(res, exp_q.pop_front());
        check(32'(lat), 32'(exp_lat));
        check({31'h0, tail}, 32'h0000_0000);
        last = res;
    endtask : run_op

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        rst = 1'b1;
        stall = 1'b0;
        last = cci_pkg::RESULT_RST;
        repeat (5) @(posedge clock);
        #1;
        rst = 1'b0;
        #1;
        check({31'h0, done}, 32'h0000_0000);
        for (int i = 0; i < 40; i++) begin
            stall = (i >= 20);
            run_op(i[1:0], $random(seed), $random(seed), 1'b0);
        end
        stall = 1'b0;
        // A start while busy must neither restart nor add a second done.
        run_op(cci_pkg::SEL_MUL, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b1);
        run_op(cci_pkg::SEL_ROT, 32'h8000_0001, 32'h0000_001F, 1'b1);
        rst = 1'b1;
        @(posedge clock);
        #1;
        rst = 1'b0;
        last = cci_pkg::RESULT_RST;
        run_op(cci_pkg::SEL_ADD, 32'hFFFF_FFFF, 32'h0000_0001, 1'b0);
        report_and_stop();
    end
endmodule : combined_custom_instruction_bench
